/* File: core/pss_defs.svh */
// Timing constants, rail count and core rail index for the power-state sequencer.
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_CLK_MHZ 125
`define PSS_SLEEP_HOLD_MS 5
`define PSS_SLEEP_HOLD_CYC (`PSS_SLEEP_HOLD_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_STEP_US 100
`define PSS_STEP_CYC (`PSS_STEP_US * `PSS_CLK_MHZ)
`define PSS_NUM_RAILS 6
`define PSS_CORE_IDX 0
`endif

/* File: core/pss_pkg.sv */
// Types for the power-state sequencer.
package pss_pkg;
  typedef enum logic [4:0] {
    PSS_OFF = 5'h01,
    PSS_POWERUP = 5'h02,
    PSS_NORMAL = 5'h04,
    PSS_LIGHT = 5'h08,
    PSS_DEEP = 5'h10
  } pss_state_t;
endpackage : pss_pkg

/* File: core/pss_step_timer.sv */
// Reloadable down-counter that pulses when a programmed interval ends.
`timescale 1ns/1ps
module pss_step_timer #(
  parameter int WIDTH = 24
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Control.
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // Status.
  output logic expired
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic running_reg;
  logic running_next;
  logic expired_next;

  always_comb begin
    count_next = count_reg;
    running_next = running_reg;
    expired_next = 1'b0;
    if (load) begin
      count_next = loadValue;
      running_next = 1'b1;
    end else if (running_reg) begin
      if (count_reg == '0) begin
        running_next = 1'b0;
        expired_next = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      running_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      count_reg <= count_next;
      running_reg <= running_next;
      expired <= expired_next;
    end
  end
endmodule : pss_step_timer

/* File: core/pmic_power_state_sequencer.sv */
// Power-state sequencer: power-up, standby states and ordered wake-up of the rails.
`timescale 1ns/1ps
`include "pss_defs.svh"
module pmic_power_state_sequencer #(
  parameter int NUM_RAILS = `PSS_NUM_RAILS,
  parameter int HOLD_CYCLES = `PSS_SLEEP_HOLD_CYC,
  parameter int STEP_CYCLES = `PSS_STEP_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Supply comparators.
  input wire logic systemSupplyAboveReset,
  input wire logic inputSupplyBelowUvlo,
  // Host power-state pins.
  input wire logic standby,
  input wire logic standbyDepthSelect,
  // Configuration straps.
  input wire logic [NUM_RAILS*3-1:0] railOrder,
  input wire logic [NUM_RAILS*24-1:0] railDelay,
  input wire logic [NUM_RAILS-1:0] deepKeepAlive,
  // Rail controls: bit 0 core, 1 memory, 2 flash io, 3 linear, 4 ext first, 5 ext second.
  output logic [NUM_RAILS-1:0] railEnable,
  output logic [NUM_RAILS-1:0] railSleep,
  output logic [2:0] powerState
);
  localparam logic [23:0] HOLD_LOAD = 24'(HOLD_CYCLES - 1);
  localparam logic [NUM_RAILS-1:0] CORE_ONLY = NUM_RAILS'(1) << `PSS_CORE_IDX;

  pss_pkg::pss_state_t state_reg, state_next;
  logic [2:0] step_reg, step_next;
  logic [NUM_RAILS-1:0] railEnable_next, railSleep_next;
  logic [2:0] powerState_next;
  logic [23:0] hold_reg, hold_next;
  logic timerLoad;
  logic [23:0] timerValue;
  logic stepDone;
  logic [2:0] curRail;
  logic [2:0] loadRail;
  logic wakeMode_reg, wakeMode_next;

  function automatic logic [2:0] orderAt(input logic [2:0] idx,
                                         input logic [NUM_RAILS*3-1:0] ord);
    orderAt = ord[idx*3 +: 3];
  endfunction : orderAt

  assign curRail = orderAt(step_reg, railOrder);
  assign loadRail = orderAt(step_next, railOrder);
  assign timerValue = railDelay[loadRail*24 +: 24];

  pss_step_timer #(.WIDTH(24)) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(stepDone)
  );

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    railEnable_next = railEnable;
    railSleep_next = railSleep;
    hold_next = (hold_reg != 24'h0) ? hold_reg - 24'h1 : hold_reg;
    wakeMode_next = wakeMode_reg;
    timerLoad = 1'b0;
    unique case (state_reg)
      pss_pkg::PSS_OFF: begin
        railEnable_next = '0;
        railSleep_next = '0;
        if (systemSupplyAboveReset && !inputSupplyBelowUvlo) begin
          state_next = pss_pkg::PSS_POWERUP;
          step_next = 3'h0;
          hold_next = HOLD_LOAD;
          wakeMode_next = 1'b0;
          timerLoad = 1'b1;
        end
      end
      pss_pkg::PSS_POWERUP: begin
        if (stepDone) begin
          if (wakeMode_reg) begin
            railSleep_next[curRail] = 1'b0;
          end else begin
            railEnable_next[curRail] = 1'b1;
          end
          if (step_reg == 3'(NUM_RAILS - 1)) begin
            state_next = pss_pkg::PSS_NORMAL;
          end else begin
            step_next = step_reg + 3'h1;
            timerLoad = 1'b1;
          end
        end
      end
      pss_pkg::PSS_NORMAL: begin
        railSleep_next = '0;
        if (!standby && hold_reg == 24'h0) begin
          if (standbyDepthSelect) begin
            state_next = pss_pkg::PSS_LIGHT;
            railSleep_next = CORE_ONLY;
          end else begin
            state_next = pss_pkg::PSS_DEEP;
            railSleep_next = '1;
            railEnable_next = deepKeepAlive;
          end
        end
      end
      pss_pkg::PSS_LIGHT, pss_pkg::PSS_DEEP: begin
        if (standby) begin
          state_next = pss_pkg::PSS_POWERUP;
          step_next = 3'h0;
          wakeMode_next = 1'b1;
          railEnable_next = '1;
          timerLoad = 1'b1;
        end
      end
      default: state_next = pss_pkg::PSS_OFF;
    endcase
    if (inputSupplyBelowUvlo) begin
      state_next = pss_pkg::PSS_OFF;
      railEnable_next = '0;
      railSleep_next = '0;
      timerLoad = 1'b0;
    end
    unique case (state_next)
      pss_pkg::PSS_OFF: powerState_next = 3'h0;
      pss_pkg::PSS_POWERUP: powerState_next = 3'h1;
      pss_pkg::PSS_NORMAL: powerState_next = 3'h2;
      pss_pkg::PSS_LIGHT: powerState_next = 3'h3;
      default: powerState_next = 3'h4;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= pss_pkg::PSS_OFF;
      step_reg <= 3'h0;
      hold_reg <= 24'h0;
      wakeMode_reg <= 1'b0;
      railEnable <= '0;
      railSleep <= '0;
      powerState <= 3'h0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      hold_reg <= hold_next;
      wakeMode_reg <= wakeMode_next;
      railEnable <= railEnable_next;
      railSleep <= railSleep_next;
      powerState <= powerState_next;
    end
  end

  // Checks on the power state and the rail controls.
  a_uvlo_shutdown: assert property (@(posedge clk) disable iff (!rst_b)
    inputSupplyBelowUvlo |=> (railEnable == '0 && powerState == 3'h0))
    else $error("rails not off after lockout");
  a_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h0) |-> (railEnable == '0 && railSleep == '0))
    else $error("rail active while off");
  a_powerup_start: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_OFF && systemSupplyAboveReset && !inputSupplyBelowUvlo)
    |=> powerState == 3'h1)
    else $error("power-up did not start");
  a_hold_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_OFF && systemSupplyAboveReset && !inputSupplyBelowUvlo)
    |=> hold_reg == HOLD_LOAD)
    else $error("hold interval not started with power-up");
  a_light_core: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h3) |-> railSleep == CORE_ONLY)
    else $error("light standby sleeps wrong rails");
  a_light_enables: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h3) |-> railEnable == '1)
    else $error("rail off in light standby");
  a_light_entry: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_NORMAL && !standby && hold_reg == 24'h0 &&
     standbyDepthSelect && !inputSupplyBelowUvlo)
    |=> (powerState == 3'h3 && railSleep == CORE_ONLY))
    else $error("light standby not entered");
  a_deep_all: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h4) |-> (railSleep == '1 && railEnable == deepKeepAlive))
    else $error("deep standby rails wrong");
  a_deep_entry: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_NORMAL && !standby && hold_reg == 24'h0 &&
     !standbyDepthSelect && !inputSupplyBelowUvlo)
    |=> (powerState == 3'h4 && railSleep == '1))
    else $error("deep standby not entered");
  a_normal_awake: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h2) |-> railSleep == '0)
    else $error("sleeping rail in normal state");
  a_normal_enabled: assert property (@(posedge clk) disable iff (!rst_b)
    (powerState == 3'h2) |-> railEnable == '1)
    else $error("rail off in normal state");
  a_hold_block: assert property (@(posedge clk) disable iff (!rst_b)
    (hold_reg != 24'h0 && state_reg == pss_pkg::PSS_NORMAL && !inputSupplyBelowUvlo)
    |=> powerState == 3'h2)
    else $error("standby honoured during hold");
  a_powerup_stay: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_POWERUP && !stepDone && !inputSupplyBelowUvlo)
    |=> powerState == 3'h1)
    else $error("sequencing left early");
  a_wake_exit: assert property (@(posedge clk) disable iff (!rst_b)
    ((powerState == 3'h3 || powerState == 3'h4) && standby && !inputSupplyBelowUvlo)
    |=> (powerState == 3'h1 && railEnable == '1))
    else $error("wake-up did not begin");
  a_wake_order: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_POWERUP && stepDone && wakeMode_reg &&
     !inputSupplyBelowUvlo) |=> !railSleep[$past(curRail)])
    else $error("rail not woken at its step");
  a_step_order: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_POWERUP && stepDone && !wakeMode_reg &&
     !inputSupplyBelowUvlo) |=> railEnable[$past(curRail)])
    else $error("rail not enabled at its step");
  a_step_single: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == pss_pkg::PSS_POWERUP && !inputSupplyBelowUvlo)
    |=> $countones(railEnable ^ $past(railEnable)) <= 1)
    else $error("more than one rail enabled in a step");
endmodule : pmic_power_state_sequencer

/* File: test/pss_host_model.sv */
// Host model that drives the standby and depth-select pins of the sequencer.
`timescale 1ns/1ps
module pss_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Commands from the bench.
  input wire logic enterStandby,
  input wire logic depthLight,
  // Host power-state pins.
  output logic standby,
  output logic standbyDepthSelect
);
  logic armed;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      standby <= 1'b1;
      standbyDepthSelect <= 1'b1;
      armed <= 1'b0;
    end else if (!enterStandby) begin
      standby <= 1'b1;
      armed <= 1'b0;
    end else if (standby) begin
      standbyDepthSelect <= depthLight;
      armed <= 1'b1;
      if (armed) begin
        standby <= 1'b0;
      end
    end
  end
endmodule : pss_host_model

/* File: test/pmic_power_state_sequencer_tb_top.sv */
// Self-checking bench for the power-state sequencer.
`timescale 1ns/1ps
module pmic_power_state_sequencer_tb_top;
  localparam logic [17:0] ORDER = 18'h25642;
  localparam logic [5:0] KEEP = 6'h05;
  localparam int HOLD = 50;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supOk = 1'b0;
  logic uvlo = 1'b0;
  logic enterStandby = 1'b0;
  logic depthLight = 1'b1;
  logic standby;
  logic standbyDepthSelect;
  logic [5:0] railEnable;
  logic [5:0] railSleep;
  logic [2:0] powerState;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  pss_host_model pss_host_model_i (.clk(clk), .rst_b(rst_b), .enterStandby(enterStandby),
    .depthLight(depthLight), .standby(standby), .standbyDepthSelect(standbyDepthSelect));
  pmic_power_state_sequencer #(.NUM_RAILS(6), .HOLD_CYCLES(HOLD), .STEP_CYCLES(4))
    pmic_power_state_sequencer_i (.clk(clk), .rst_b(rst_b),
    .systemSupplyAboveReset(supOk), .inputSupplyBelowUvlo(uvlo), .standby(standby),
    .standbyDepthSelect(standbyDepthSelect), .railOrder(ORDER),
    .railDelay({6{24'h000003}}), .deepKeepAlive(KEEP), .railEnable(railEnable),
    .railSleep(railSleep), .powerState(powerState));
  task automatic wrap_up();
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 200 && powerState !== s; i++) @(negedge clk);
    check(8'(powerState), 8'(s));
  endtask : wait_state
  // Watches one rail vector change a single bit per step, in strap order.
  task automatic order_check(input logic useSleep);
    logic [5:0] prev;
    logic [5:0] now;
    prev = useSleep ? railSleep : railEnable;
    for (int k = 0; k < 6; k++) begin
      now = prev;
      for (int i = 0; i < 50 && now === prev; i++) begin
        @(negedge clk);
        now = useSleep ? railSleep : railEnable;
      end
      check(8'(now ^ prev), 8'(6'h01 << ORDER[3*k+:3]));
      prev = now;
    end
  endtask : order_check
  task automatic powerup_then_light();
    int startCyc;
    @(posedge clk) supOk <= 1'b1;
    wait_state(3'h1);
    startCyc = cycles;
    order_check(1'b0);
    wait_state(3'h2);
    @(posedge clk) enterStandby <= 1'b1;
    repeat (8) @(negedge clk);
    check(8'(powerState), 8'h02);
    wait_state(3'h3);
    check(8'(cycles - startCyc), 8'(HOLD));
    check(8'(railSleep), 8'h01);
    check(8'(railEnable), 8'h3f);
  endtask : powerup_then_light
  task automatic wake_then_deep();
    @(posedge clk) enterStandby <= 1'b0;
    wait_state(3'h2);
    check(8'(railSleep), 8'h00);
    check(8'(railEnable), 8'h3f);
    @(posedge clk);
    depthLight <= 1'b0;
    enterStandby <= 1'b1;
    wait_state(3'h4);
    check(8'(railSleep), 8'h3f);
    check(8'(railEnable), 8'(KEEP));
    @(posedge clk) enterStandby <= 1'b0;
    wait_state(3'h1);
    order_check(1'b1);
    wait_state(3'h2);
  endtask : wake_then_deep
  task automatic lockout();
    @(posedge clk) uvlo <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    check(8'(powerState), 8'h00);
    check(8'(railEnable), 8'h00);
    check(8'(railSleep), 8'h00);
  endtask : lockout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    powerup_then_light();
    wake_then_deep();
    lockout();
    wrap_up();
  end
endmodule : pmic_power_state_sequencer_tb_top
